// ===== hw/clk_startup_pkg.sv
`default_nettype none
package clk_startup_pkg;

    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FUSE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0c;
    localparam int CTRL_SLEEP_BIT = 0;

    // Clock source select codes
    localparam logic [3:0] CKS_EXTERNAL = 4'h0;
    localparam logic [3:0] CKS_RESERVED = 4'h1;
    localparam logic [3:0] CKS_RC = 4'h2;
    localparam logic [3:0] CKS_RC128 = 4'h3;
    localparam logic [2:0] CKS_FULL_SWING_HI = 3'h3;
    localparam logic [2:0] CKS_LOW_FREQ_HI = 3'h2;

    // Watchdog oscillator cycles of the supply time-out
    localparam logic [CNT_W-1:0] TOUT_NONE = 16'h0000;
    localparam logic [CNT_W-1:0] TOUT_SHORT = 16'h0200;
    localparam logic [CNT_W-1:0] TOUT_LONG = 16'h2000;

    // Oscillator cycles of stabilisation
    localparam logic [CNT_W-1:0] STAB_EXT = 16'h0006;
    localparam logic [CNT_W-1:0] STAB_258 = 16'h0102;
    localparam logic [CNT_W-1:0] STAB_1K = 16'h0400;
    localparam logic [CNT_W-1:0] STAB_16K = 16'h4000;
    localparam logic [CNT_W-1:0] STAB_32K = 16'h8000;
    localparam logic [CNT_W-1:0] RESET_EXTRA = 16'h000e;

    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [1:0] PIN_SYNC_RST = 2'h0;

    typedef struct packed {
        logic div8;
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_source_select_fuses;
    } fuse_s;

    localparam fuse_s FUSE_DEFAULT = '{div8: 1'h0, startup_time_fuses: 2'h2, clock_source_select_fuses: 4'h2};

    typedef struct packed {
        logic [CNT_W-1:0] tout;
        logic [CNT_W-1:0] stab;
    } startup_s;

    typedef enum logic [2:0] {
        st_hold,
        st_timeout,
        st_stabilise,
        st_run,
        st_sleep
    } seq_state_e;

    typedef enum logic [2:0] {
        ct_external,
        ct_rc128,
        ct_rc,
        ct_low_freq,
        ct_full_swing,
        ct_low_power,
        ct_reserved
    } clk_type_e;

endpackage
`default_nettype wire

// ===== hw/tick_counter.sv
`default_nettype none
module tick_counter
    import clk_startup_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic tick_in,
    input wire logic run,
    input wire logic [CNT_W-1:0] target,
    output logic tick_edge,
    output logic [CNT_W-1:0] count,
    output logic done
);

    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [CNT_W-1:0] count_q;

    // Two-stage synchroniser, then edge history
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
            prev_q <= 1'h0;
        end else if (ce) begin
            meta_q <= tick_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign tick_edge = sync_q & ~prev_q;
    assign done = run && (count_q == target);
    assign count = count_q;

    // Counts rising edges while running, restarts from zero when idle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (ce) begin
            if (!run) begin
                count_q <= '0;
            end else if (tick_edge && !done) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

endmodule
`default_nettype wire

// ===== hw/clock_startup_reset_sequencer.sv
// Decided for this implementation: the APB slave port and the register offsets.
`default_nettype none
// Overview of operation
// - Defaults: calibrated RC, divide-by-eight, code 10
// - Hold internal reset after sources release
// - Time-out counts watchdog cycles, fuse selected
// - Time-out lengths are 0, 512, 8192
// - Ripple counter holds reset, then releases
// - Stabilisation count depends on clock type
// - From reset: time-out then stabilisation
// - Wake from deep sleep: stabilisation only
// - Upper select bits give low-power frequency mode
// - Lowest select bit plus start-up code pick timing
// - Bit0=0, 00/01: 258 cycles, short/long
// - 0/10, 0/11, 1/00: 1K cycles
// - Bit0=1, 01/10/11: 16K cycles
// - Divide-by-eight fuse divides system clock
// - Four select bits decode the clock source
module clock_startup_reset_sequencer
    import clk_startup_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic reset_sources_n,
    input wire logic wake_pin,
    input wire logic wdt_osc,
    input wire logic osc_clk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic internal_reset_n,
    output logic sys_clk_en
);

    localparam int SRC_IDX = 0;
    localparam int WAKE_IDX = 1;

    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic wake_prev_q;
    logic sources_released;
    logic wake_edge;

    fuse_s fuse_q;
    seq_state_e state_q;
    logic from_reset_q;
    logic internal_reset_n_q;
    logic sys_clk_en_q;
    logic [2:0] div_cnt_q;

    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    clk_type_e clk_type;
    startup_s sel;
    logic [2:0] lp_mode;
    logic [CNT_W-1:0] stab_target;

    logic tout_run;
    logic stab_run;
    logic tout_done;
    logic stab_done;
    logic osc_edge;
    logic [CNT_W-1:0] tout_count;
    logic [CNT_W-1:0] stab_count;

    logic apb_access;
    logic apb_write;
    logic sleep_req;

    // Pin synchronisers for reset sources and wake
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= PIN_SYNC_RST;
            pin_sync_q <= PIN_SYNC_RST;
        end else if (ce) begin
            pin_meta_q <= {wake_pin, reset_sources_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_prev_q <= 1'h0;
        end else if (ce) begin
            wake_prev_q <= pin_sync_q[WAKE_IDX];
        end
    end

    assign sources_released = pin_sync_q[SRC_IDX];
    assign wake_edge = pin_sync_q[WAKE_IDX] & ~wake_prev_q;

    // Clock source decode
    always_comb begin
        clk_type = ct_low_power;
        if (fuse_q.clock_source_select_fuses[3]) begin
            clk_type = ct_low_power;
        end else if (fuse_q.clock_source_select_fuses[3:1] == CKS_FULL_SWING_HI) begin
            clk_type = ct_full_swing;
        end else if (fuse_q.clock_source_select_fuses[3:1] == CKS_LOW_FREQ_HI) begin
            clk_type = ct_low_freq;
        end else if (fuse_q.clock_source_select_fuses == CKS_RC128) begin
            clk_type = ct_rc128;
        end else if (fuse_q.clock_source_select_fuses == CKS_RC) begin
            clk_type = ct_rc;
        end else if (fuse_q.clock_source_select_fuses == CKS_EXTERNAL) begin
            clk_type = ct_external;
        end else if (fuse_q.clock_source_select_fuses == CKS_RESERVED) begin
            clk_type = ct_reserved;
        end
    end

    // Low-power crystal frequency mode
    always_comb begin
        lp_mode = 3'h0;
        if (clk_type == ct_low_power) begin
            lp_mode = fuse_q.clock_source_select_fuses[3:1];
        end
    end

    // Start-up timing table per clock type
    always_comb begin
        sel.tout = TOUT_LONG;
        sel.stab = STAB_EXT;
        case (clk_type)
            ct_low_power, ct_full_swing: begin
                case ({fuse_q.clock_source_select_fuses[0], fuse_q.startup_time_fuses})
                    3'h0: begin
                        sel.stab = STAB_258;
                        sel.tout = TOUT_SHORT;
                    end
                    3'h1: begin
                        sel.stab = STAB_258;
                        sel.tout = TOUT_LONG;
                    end
                    3'h2: begin
                        sel.stab = STAB_1K;
                        sel.tout = TOUT_NONE;
                    end
                    3'h3: begin
                        sel.stab = STAB_1K;
                        sel.tout = TOUT_SHORT;
                    end
                    3'h4: begin
                        sel.stab = STAB_1K;
                        sel.tout = TOUT_LONG;
                    end
                    3'h5: begin
                        sel.stab = STAB_16K;
                        sel.tout = TOUT_NONE;
                    end
                    3'h6: begin
                        sel.stab = STAB_16K;
                        sel.tout = TOUT_SHORT;
                    end
                    default: begin
                        sel.stab = STAB_16K;
                        sel.tout = TOUT_LONG;
                    end
                endcase
            end
            ct_low_freq: begin
                sel.stab = fuse_q.clock_source_select_fuses[0] ? STAB_32K : STAB_1K;
                case (fuse_q.startup_time_fuses)
                    2'h0: sel.tout = TOUT_NONE;
                    2'h1: sel.tout = TOUT_SHORT;
                    default: sel.tout = TOUT_LONG;
                endcase
            end
            default: begin
                sel.stab = STAB_EXT;
                case (fuse_q.startup_time_fuses)
                    2'h0: sel.tout = TOUT_NONE;
                    2'h1: sel.tout = TOUT_SHORT;
                    default: sel.tout = TOUT_LONG;
                endcase
            end
        endcase
    end

    // From reset the extra clock cycles are added
    always_comb begin
        if (from_reset_q) begin
            stab_target = sel.stab + RESET_EXTRA;
        end else begin
            stab_target = sel.stab;
        end
    end

    assign tout_run = (state_q == st_timeout);
    assign stab_run = (state_q == st_stabilise);

    // Supply time-out on the watchdog oscillator
    tick_counter u_tout (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .tick_in(wdt_osc),
        .run(tout_run),
        .target(sel.tout),
        .tick_edge(),
        .count(tout_count),
        .done(tout_done)
    );

    // Ripple counter on the selected oscillator
    tick_counter u_stab (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .tick_in(osc_clk),
        .run(stab_run),
        .target(stab_target),
        .tick_edge(osc_edge),
        .count(stab_count),
        .done(stab_done)
    );

    // Sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= st_hold;
        end else if (ce) begin
            if (!sources_released) begin
                state_q <= st_hold;
            end else begin
                case (state_q)
                    st_hold: state_q <= st_timeout;
                    st_timeout: begin
                        if (tout_done) begin
                            state_q <= st_stabilise;
                        end
                    end
                    st_stabilise: begin
                        if (stab_done) begin
                            state_q <= st_run;
                        end
                    end
                    st_run: begin
                        if (sleep_req) begin
                            state_q <= st_sleep;
                        end
                    end
                    st_sleep: begin
                        if (wake_edge) begin
                            state_q <= st_stabilise;
                        end
                    end
                    default: state_q <= st_hold;
                endcase
            end
        end
    end

    // Remembers whether stabilisation follows a reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            from_reset_q <= 1'h1;
        end else if (ce) begin
            if (state_q == st_hold) begin
                from_reset_q <= 1'h1;
            end else if (state_q == st_sleep) begin
                from_reset_q <= 1'h0;
            end
        end
    end

    // Internal reset output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            internal_reset_n_q <= 1'h0;
        end else if (ce) begin
            if (!sources_released || state_q == st_hold) begin
                internal_reset_n_q <= 1'h0;
            end else if (stab_run && stab_done) begin
                internal_reset_n_q <= 1'h1;
            end
        end
    end

    // System clock enable with optional divide by eight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= 3'h0;
            sys_clk_en_q <= 1'h0;
        end else if (ce) begin
            if (state_q != st_run || !sources_released) begin
                div_cnt_q <= 3'h0;
                sys_clk_en_q <= 1'h0;
            end else if (osc_edge) begin
                div_cnt_q <= div_cnt_q + 3'h1;
                if (!fuse_q.div8) begin
                    sys_clk_en_q <= (div_cnt_q == DIV8_LAST);
                end else begin
                    sys_clk_en_q <= 1'h1;
                end
            end else begin
                sys_clk_en_q <= 1'h0;
            end
        end
    end

    // APB slave
    assign apb_access = psel & penable;
    assign apb_write = apb_access & pready_q & pwrite;
    assign sleep_req = apb_write && (paddr == OFF_CTRL) && pwdata[CTRL_SLEEP_BIT];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'h0;
        end else if (ce) begin
            pready_q <= apb_access & ~pready_q;
        end
    end

    // Fuse register, shipped defaults at reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fuse_q <= FUSE_DEFAULT;
        end else if (ce) begin
            if (apb_write && paddr == OFF_FUSE) begin
                fuse_q <= pwdata[$bits(fuse_s)-1:0];
            end
        end
    end

    // Read data and error flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'h0;
        end else if (ce) begin
            if (apb_access && !pready_q) begin
                pslverr_q <= 1'h0;
                prdata_q <= '0;
                if (paddr == OFF_FUSE) begin
                    prdata_q <= {25'h0, fuse_q};
                end else if (paddr == OFF_CTRL) begin
                    prdata_q <= '0;
                end else if (paddr == OFF_STATUS) begin
                    prdata_q <= {21'h0, clk_type, lp_mode, from_reset_q,
                                 ~internal_reset_n_q, state_q};
                end else if (paddr == OFF_COUNT) begin
                    prdata_q <= {tout_count, stab_count};
                end else begin
                    pslverr_q <= 1'h1;
                end
            end else begin
                pslverr_q <= 1'h0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign internal_reset_n = internal_reset_n_q;
    assign sys_clk_en = sys_clk_en_q;

endmodule
`default_nettype wire

// ===== verification/clk_startup_props.sv
`default_nettype none
module clk_startup_props
    import clk_startup_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic reset_sources_n,
    input wire logic wake_pin,
    input wire logic wdt_osc,
    input wire logic osc_clk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic internal_reset_n,
    input wire logic sys_clk_en
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_hold_on_src: assert property ((!reset_sources_n) [*5] |-> !internal_reset_n)
        else $error("internal reset not held");
    a_release_after_src: assert property ($rose(internal_reset_n) |-> $past(reset_sources_n, 3))
        else $error("reset released too early");
    a_clk_en_run: assert property (sys_clk_en |-> internal_reset_n)
        else $error("clock enable during reset");
    a_clk_en_single: assert property (sys_clk_en |=> !sys_clk_en)
        else $error("clock enable longer than one cycle");
    a_ready_after: assert property (psel && penable && !pready |=> pready)
        else $error("ready not after one wait state");
    a_ready_one: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access");
    a_err_unmapped: assert property (pslverr |-> pready &&
        ($past(paddr) > 8'h0c || ($past(paddr) & 8'h03) != 8'h00))
        else $error("error on mapped address");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
endmodule
bind clock_startup_reset_sequencer clk_startup_props u_props (.clk(clk), .resetn(resetn),
    .ce(ce), .reset_sources_n(reset_sources_n), .wake_pin(wake_pin), .wdt_osc(wdt_osc),
    .osc_clk(osc_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_reset_n(internal_reset_n), .sys_clk_en(sys_clk_en));
`default_nettype wire

// ===== verification/osc_source.sv
`default_nettype none
module osc_source #(
    parameter int HALF = 1
) (
    input wire logic clk,
    input wire logic free_run,
    input wire logic go,
    input wire logic [15:0] burst,
    output logic busy,
    output logic wave
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] rem_q = '0;
    logic [7:0] div_q = '0;
    initial wave = 1'b0;
    assign busy = go || rem_q != '0;
    // Bursts of whole periods, then still and low
    always @(posedge clk) begin
        if (go) begin
            rem_q <= {burst, 1'b0};
            div_q <= '0;
        end else if (free_run || rem_q != '0) begin
            if (div_q == 8'(HALF - 1)) begin
                div_q <= '0;
                wave <= ~wave;
                if (rem_q != '0) rem_q <= rem_q - 17'h1;
            end else begin
                div_q <= div_q + 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_clock_startup_reset_sequencer.sv
`default_nettype none
module tb_clock_startup_reset_sequencer import clk_startup_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, reset_sources_n, wake_pin, psel, penable, pwrite, go, busy, err;
    logic wdt_osc, osc_clk, pready, pslverr, internal_reset_n, sys_clk_en, ce;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [15:0] burst;
    int fail_count = 0;
    int samples_checked = 0;
    int pulses = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (sys_clk_en === 1'b1) pulses++;
    clock_startup_reset_sequencer dut (.clk(clk), .resetn(resetn), .ce(ce),
        .reset_sources_n(reset_sources_n), .wake_pin(wake_pin), .wdt_osc(wdt_osc),
        .osc_clk(osc_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_reset_n(internal_reset_n), .sys_clk_en(sys_clk_en));
    osc_source #(.HALF(1)) wdt_src (.clk(clk), .free_run(1'b1), .go(1'b0), .burst(16'h0),
        .busy(), .wave(wdt_osc));
    osc_source #(.HALF(1)) osc_src (.clk(clk), .free_run(1'b0), .go(go), .burst(burst),
        .busy(busy), .wave(osc_clk));
    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic osc_edges(input int n);
        int k;
        @(posedge clk);
        burst <= 16'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (busy === 1'b1 && k < 100000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100000) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic state_is(input logic [2:0] s);
        apb(1'b0, OFF_STATUS, '0);
        check(rd & 32'h7, {29'h0, s});
    endtask
    task automatic run_seq(input logic [6:0] fz, input int tout, input int stab);
        reset_sources_n <= 1'b0;
        apb(1'b1, OFF_FUSE, {25'h0, fz});
        repeat (8) @(posedge clk);
        check({31'h0, internal_reset_n}, 32'h0);
        reset_sources_n <= 1'b1;
        if (tout != 0) begin
            repeat (2 * tout - 16) @(posedge clk);
            state_is(3'h1);
        end
        repeat (24) @(posedge clk);
        state_is(3'h2);
        osc_edges(stab - 1);
        repeat (8) @(posedge clk);
        check({31'h0, internal_reset_n}, 32'h0);
        apb(1'b0, OFF_COUNT, '0);
        check(rd, 32'(stab - 1));
        osc_edges(1);
        repeat (8) @(posedge clk);
        check({31'h0, internal_reset_n}, 32'h1);
        state_is(3'h3);
    endtask
    task automatic div_check(input int exp);
        pulses = 0;
        osc_edges(16);
        repeat (8) @(posedge clk);
        check(32'(pulses), 32'(exp));
    endtask
    function automatic logic [2:0] ktype(input int c);
        return c > 7 ? 3'h5 : c > 5 ? 3'h4 : c > 3 ? 3'h3 : c == 3 ? 3'h1 : c == 2 ? 3'h2 :
            c == 1 ? 3'h6 : 3'h0;
    endfunction
    initial begin
        clk = 1'b0;
        ce = 1'b1;
        resetn = 1'b0;
        reset_sources_n = 1'b0;
        wake_pin = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        go = 1'b0;
        burst = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, OFF_FUSE, '0);
        check(rd, 32'h22);
        apb(1'b0, OFF_STATUS, '0);
        check(rd & 32'h7ef, 32'h208);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, OFF_FUSE, 32'h40 | 32'(i));
            apb(1'b0, OFF_STATUS, '0);
            check(rd & 32'h7e0, {21'h0, ktype(i), i > 7 ? 3'(i >> 1) : 3'h0, 5'h0});
        end
        apb(1'b0, 8'h10, '0);
        check({rd[30:0], err}, 32'h1);
        run_seq(7'h22, 8192, 20);
        div_check(2);
        run_seq(7'h48, 512, 272);
        run_seq(7'h68, 0, 1038);
        run_seq(7'h59, 0, 16398);
        run_seq(7'h50, 512, 20);
        div_check(16);
        ce <= 1'b0;
        div_check(0);
        ce <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h1);
        state_is(3'h4);
        div_check(0);
        wake_pin <= 1'b1;
        repeat (8) @(posedge clk);
        osc_edges(5);
        state_is(3'h2);
        check(rd & 32'h10, 32'h0);
        osc_edges(1);
        repeat (8) @(posedge clk);
        state_is(3'h3);
        check({31'h0, internal_reset_n}, 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
